// >>> design/rcu_pkg.sv
// Package for the rotate and carry datapath: operations, sources, timing.
package rcu_pkg;

	// ****************************************
	// Operation and count source encodings
	// ****************************************
	typedef enum logic [1:0] {
		RCU_OP_ROTATE_RIGHT = 2'h0,
		RCU_OP_RCL          = 2'h1,
		RCU_OP_RCR          = 2'h2
	} rcu_op_t;

	typedef enum logic [1:0] {
		RCU_CNT_ONE  = 2'h0,
		RCU_CNT_REG  = 2'h1,
		RCU_CNT_IMM  = 2'h2
	} rcu_cnt_src_t;

	typedef struct packed {
		rcu_op_t      op;
		rcu_cnt_src_t cnt_src;
		logic         word;
		logic         is_mem;
		logic         odd_addr;
		logic [1:0]   disp_len;
		logic [15:0]  operand;
		logic [7:0]   count_low_reg;
		logic [7:0]   imm8;
		logic         carry_flag;
		logic         range_flag;
	} rcu_req_t;

	typedef struct packed {
		logic [15:0] result;
		logic        carry_flag;
		logic        range_flag;
		logic        range_valid;
		logic [2:0]  length;
		logic [5:0]  bus_xfers;
		logic [8:0]  clocks;
	} rcu_rsp_t;

	// ****************************************
	// Lengths, clock counts and transfers
	// ****************************************
	localparam logic [2:0] RCU_LEN_IMM_BASE  = 3'h3;
	localparam logic [2:0] RCU_LEN_OTHER_BASE = 3'h2;
	localparam logic [8:0] RCU_CLK_REG_ONE   = 9'h002;
	localparam logic [8:0] RCU_CLK_REG_VAR   = 9'h007;
	localparam logic [8:0] RCU_CLK_MEM_ONE_S = 9'h010;
	localparam logic [8:0] RCU_CLK_MEM_ONE_L = 9'h018;
	localparam logic [8:0] RCU_CLK_MEM_VAR_S = 9'h013;
	localparam logic [8:0] RCU_CLK_MEM_VAR_L = 9'h01B;
	localparam logic [5:0] RCU_XFER_MEM      = 6'h02;
	localparam int         RCU_MSB_BYTE      = 7;
	localparam int         RCU_MSB_WORD      = 15;

endpackage

// >>> design/rcu_rotate_carry_unit.sv
// Rotate and carry unit: sequences one rotate instruction step by step.
`timescale 1ns/1ps

// Behaviour
// RL1: Memory right rotate by immediate copies outgoing LSB to MSB and carry.
// RL2: Register right rotate by immediate behaves the same way.
// RL3: Single left through carry: carry gets MSB, old carry enters LSB.
// RL4: After single left through carry, range flag is result MSB xor carry.
// RL5: Single right through carry: carry gets LSB, old carry enters MSB.
// RL6: After single right through carry, range flag is MSB xor next bit.
// RL7: Variable left through carry repeats steps count-low-register times.
// RL8: Variable right through carry repeats steps count-low-register times.
// RL9: Immediate forms take the count from the 8-bit immediate byte.
// RL10: Size bit zero rotates 8 bits, one rotates 16 bits.
// RL11: Immediate forms take 3 to 5 bytes memory, 3 bytes register.
// RL12: One-bit and register-count forms take 2 to 4 bytes memory, 2 register.
// RL13: Register forms take 7 plus n clocks, or 2 for single bit.
// RL14: Memory counted forms take 19 plus n, or 27 plus n for slow words.
// RL15: Memory single-bit forms take 16, or 24 for slow words.
// RL16: Other flags untouched; range flag undefined for counted forms.
// RL17: Memory forms make two bus transfers, register forms none.
// RL18: A zero count leaves operand and carry unchanged.
module rcu_rotate_carry_unit
	import rcu_pkg::*;
#(
	parameter bit WIDE_BUS = 1'b1
) (
	input  wire logic     i_clk_sys,
	input  wire logic     i_rst,
	input  wire logic     i_start,
	input  wire rcu_req_t i_req,
	output logic          o_busy,
	output logic          o_done,
	output rcu_rsp_t      o_rsp
);

	typedef enum logic [1:0] {
		RCU_IDLE = 2'b00,
		RCU_STEP = 2'b01,
		RCU_DONE = 2'b11
	} rcu_state_t;

	rcu_state_t  state;
	rcu_op_t     op;
	logic        word;
	logic        fixed_one;
	logic [7:0]  count;
	logic [15:0] data;
	logic        carry;
	logic        range;
	logic [15:0] next_data;
	logic        next_carry;
	logic        next_range;
	logic        take;
	logic        stepping;

	// ****************************************
	// One rotate step at the selected width
	// ****************************************
	function automatic logic msb_of(input logic [15:0] v, input logic w);
		return w ? v[RCU_MSB_WORD] : v[RCU_MSB_BYTE]; // RL10
	endfunction

	function automatic logic below_msb_of(input logic [15:0] v, input logic w);
		return w ? v[RCU_MSB_WORD - 1] : v[RCU_MSB_BYTE - 1];
	endfunction

	// One-bit forms count a single step; the others take the register or the immediate byte.
	function automatic logic [7:0] count_of(input rcu_req_t r);
		logic [7:0] n;
		unique case (r.cnt_src)
			RCU_CNT_REG: n = r.count_low_reg; // RL7 RL8
			RCU_CNT_IMM: n = r.imm8; // RL9
			default:     n = 8'h01;
		endcase
		return n;
	endfunction

	// Words are slow on the narrow bus, and on the wide bus when they sit at an odd address.
	function automatic logic slow_word(input rcu_req_t r);
		return r.word && (!WIDE_BUS || r.odd_addr); // RL14 RL15
	endfunction

	function automatic logic [2:0] length_of(input rcu_req_t r);
		logic [2:0] base;
		base = (r.cnt_src == RCU_CNT_IMM) ? RCU_LEN_IMM_BASE : RCU_LEN_OTHER_BASE;
		return base + (r.is_mem ? {1'b0, r.disp_len} : 3'h0); // RL11 RL12
	endfunction

	function automatic logic [8:0] clocks_of(input rcu_req_t r);
		logic [8:0] steps;
		logic [8:0] clk;
		steps = {1'b0, count_of(r)};
		if (!r.is_mem) begin
			clk = (r.cnt_src == RCU_CNT_ONE) ? RCU_CLK_REG_ONE
				: (RCU_CLK_REG_VAR + steps); // RL13
		end else if (r.cnt_src == RCU_CNT_ONE) begin
			clk = slow_word(r) ? RCU_CLK_MEM_ONE_L : RCU_CLK_MEM_ONE_S; // RL15
		end else begin
			clk = (slow_word(r) ? RCU_CLK_MEM_VAR_L : RCU_CLK_MEM_VAR_S) + steps; // RL14
		end
		return clk;
	endfunction

	// A start is only taken while idle; a step is only made while count remains.
	assign take     = (state == RCU_IDLE) && i_start;
	assign stepping = (state == RCU_STEP) && (count != 8'h00);

	always_comb begin
		next_data  = data;
		next_carry = carry;
		next_range = range;
		unique case (op)
			RCU_OP_ROTATE_RIGHT: begin
				next_carry = data[0]; // RL1 RL2
				next_data  = word ? {data[0], data[15:1]} : {8'h00, data[0], data[7:1]};
			end
			RCU_OP_RCL: begin
				next_carry = msb_of(data, word); // RL3
				next_data  = word ? {data[14:0], carry} : {8'h00, data[6:0], carry};
				next_range = msb_of(next_data, word) ^ next_carry; // RL4
			end
			RCU_OP_RCR: begin
				next_carry = data[0]; // RL5
				next_data  = word ? {carry, data[15:1]} : {8'h00, carry, data[7:1]};
				next_range = msb_of(next_data, word) ^ below_msb_of(next_data, word); // RL6
			end
			default: begin
				next_data = data;
			end
		endcase
	end

	// ****************************************
	// Sequencing
	// ****************************************
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state <= RCU_IDLE;
		end else begin
			unique case (state)
				RCU_IDLE: begin
					if (i_start) begin
						state <= RCU_STEP;
					end
				end
				RCU_STEP: begin
					if (count == 8'h00) begin
						state <= RCU_DONE; // RL18
					end
				end
				RCU_DONE: begin
					state <= RCU_IDLE;
				end
				default: begin
					state <= RCU_IDLE;
				end
			endcase
		end
	end

	// The step count is loaded at the start and falls by one with every rotate step.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			count <= 8'h00;
		end else if (take) begin
			count <= count_of(i_req); // RL7 RL8 RL9
		end else if (stepping) begin
			count <= count - 8'h01;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			op        <= RCU_OP_ROTATE_RIGHT;
			word      <= 1'b0;
			fixed_one <= 1'b0;
		end else if (take) begin
			op        <= i_req.op;
			word      <= i_req.word;
			fixed_one <= (i_req.cnt_src == RCU_CNT_ONE);
		end
	end

	// A zero count never steps, so operand and carry leave exactly as they came in.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			data  <= 16'h0000;
			carry <= 1'b0;
			range <= 1'b0;
		end else if (take) begin
			data  <= i_req.word ? i_req.operand : {8'h00, i_req.operand[7:0]}; // RL10
			carry <= i_req.carry_flag;
			range <= i_req.range_flag; // RL16
		end else if (stepping) begin
			data  <= next_data; // RL7 RL8
			carry <= next_carry;
			range <= next_range;
		end
	end

	// ****************************************
	// Outputs and instruction accounting
	// ****************************************
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= take || (state == RCU_STEP);
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_done <= 1'b0;
		end else begin
			o_done <= (state == RCU_DONE);
		end
	end

	// Length, clocks and transfers are known at the start; the result follows with done.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rsp <= '0;
		end else if (take) begin
			o_rsp.result      <= 16'h0000;
			o_rsp.carry_flag  <= 1'b0;
			o_rsp.range_flag  <= 1'b0;
			o_rsp.range_valid <= 1'b0;
			o_rsp.bus_xfers   <= i_req.is_mem ? RCU_XFER_MEM : 6'h00; // RL17
			o_rsp.length      <= length_of(i_req); // RL11 RL12
			o_rsp.clocks      <= clocks_of(i_req); // RL13 RL14 RL15
		end else if (state == RCU_DONE) begin
			o_rsp.result      <= data;
			o_rsp.carry_flag  <= carry;
			o_rsp.range_flag  <= range;
			o_rsp.range_valid <= fixed_one && op != RCU_OP_ROTATE_RIGHT; // RL16
		end
	end

endmodule

// >>> verif/rcu_chk.sv
// Port checker for the rotate and carry unit.
`timescale 1ns/1ps
module rcu_chk
	import rcu_pkg::*;
(
	input  wire logic     i_clk_sys,
	input  wire logic     i_rst,
	input  wire logic     i_start,
	input  wire rcu_req_t i_req,
	input  wire logic     o_busy,
	input  wire logic     o_done,
	input  wire rcu_rsp_t o_rsp
);
	logic go;
	// Busy is low exactly while the unit is idle, so a start seen with busy low is taken.
	assign go = i_start && !o_busy;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	property p_pulse; o_done |=> !o_done; endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_fall; $fell(o_busy) |-> o_done; endproperty
	a_fall: assert property (p_fall) else $error("done late");
	property p_take; go |=> o_busy; endproperty
	a_take: assert property (p_take) else $error("start lost");
	property p_one; go && i_req.cnt_src == RCU_CNT_ONE |-> ##4 o_done; endproperty
	a_one: assert property (p_one) else $error("single step latency");
	property p_zero; go && i_req.cnt_src == RCU_CNT_IMM && i_req.imm8 == 8'h00 |->
		##3 o_done && o_rsp.carry_flag == $past(i_req.carry_flag, 3); endproperty
	a_zero: assert property (p_zero) else $error("zero count");
	property p_xfer; go |=> o_rsp.bus_xfers == ($past(i_req.is_mem) ? 6'h02 : 6'h00); endproperty
	a_xfer: assert property (p_xfer) else $error("transfers");
	property p_len; go && i_req.cnt_src == RCU_CNT_IMM && !i_req.is_mem |=>
		o_rsp.length == 3'h3; endproperty
	a_len: assert property (p_len) else $error("length");
	property p_rcl; go && i_req.op == RCU_OP_RCL && i_req.cnt_src == RCU_CNT_ONE && !i_req.word
		|-> ##4 o_rsp.carry_flag == $past(i_req.operand[7], 4) && o_rsp.result[7:0] ==
		{$past(i_req.operand[6:0], 4), $past(i_req.carry_flag, 4)}; endproperty
	a_rcl: assert property (p_rcl) else $error("left through carry");
	property p_byte; go && !i_req.word && i_req.cnt_src == RCU_CNT_ONE |->
		##4 o_rsp.result[15:8] == 8'h00; endproperty
	a_byte: assert property (p_byte) else $error("byte upper bits");
	c_mem: cover property (go && i_req.is_mem);
	c_rcr: cover property (go && i_req.op == RCU_OP_RCR);
	c_end: cover property ($fell(o_busy));
endmodule

bind rcu_rotate_carry_unit rcu_chk u_chk (.i_clk_sys, .i_rst, .i_start, .i_req, .o_busy,
	.o_done, .o_rsp);

// >>> verif/rotate_carry_unit_test.sv
// Self-checking bench for the rotate and carry unit.
`timescale 1ns/1ps
module rotate_carry_unit_test;
	import rcu_pkg::*;
	logic     i_clk_sys = 1'b0;
	logic     i_rst = 1'b1;
	logic     i_start = 1'b0;
	rcu_req_t i_req = '0;
	logic     o_busy, o_done;
	rcu_rsp_t o_rsp;
	int       failures = 0;
	int       samples_checked = 0;
	rcu_rotate_carry_unit #(.WIDE_BUS(1'b1)) dut (.i_clk_sys, .i_rst, .i_start, .i_req,
		.o_busy, .o_done, .o_rsp);
	initial begin
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	task test_done;
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(string nm, logic [34:0] s, logic [34:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// f holds word, memory and odd-address bits; n is the count of the chosen source.
	task run(rcu_op_t op, rcu_cnt_src_t cs, logic [2:0] f, logic [1:0] dl, logic [15:0] v,
		logic [7:0] n, logic cy);
		int k, m, e;
		logic [15:0] r;
		logic c, t;
		logic [8:0] ck;
		m = f[2] ? 15 : 7;
		r = f[2] ? v : {8'h00, v[7:0]};
		c = cy;
		e = cs == RCU_CNT_ONE ? 1 : n;
		repeat (e) begin
			t = op == RCU_OP_RCL ? r[m] : r[0];
			r = op == RCU_OP_RCL ? {r[14:0], c} : r >> 1;
			if (op != RCU_OP_RCL) r[m] = op == RCU_OP_RCR ? c : t;
			c = t;
		end
		r[15:8] = f[2] ? r[15:8] : 8'h00;
		ck = cs == RCU_CNT_ONE ? (f[1] ? (f[2] && f[0] ? 9'h018 : 9'h010) : 9'h002)
			: 9'(e) + (f[1] ? (f[2] && f[0] ? 9'h01B : 9'h013) : 9'h007);
		@(negedge i_clk_sys);
		// The unused count source gets the inverse so a wrong source shows up.
		i_req = '{op, cs, f[2], f[1], f[0], dl, v, cs == RCU_CNT_IMM ? ~n : n,
			cs == RCU_CNT_IMM ? n : ~n, cy, ~cy};
		i_start = 1'b1;
		@(negedge i_clk_sys);
		i_start = 1'b0;
		for (k = 0; k < 300 && o_done !== 1'b1; k++) @(negedge i_clk_sys);
		chk("cycles", 35'(k), 35'(e + 2));
		if (k == 300) test_done;
		chk("rsp", {o_rsp.result, o_rsp.carry_flag, o_rsp.length, o_rsp.bus_xfers,
			o_rsp.clocks}, {r, c, (cs == RCU_CNT_IMM ? 3'h3 : 2'h2) + (f[1] ? dl : 2'h0),
			f[1] ? 6'h02 : 6'h00, ck});
		if (cs == RCU_CNT_ONE)
			chk("range", {o_rsp.range_valid, o_rsp.range_flag},
				{1'b1, r[m] ^ (op == RCU_OP_RCL ? c : r[m - 1])});
		else
			chk("range_valid", 35'(o_rsp.range_valid), 35'h0);
		@(negedge i_clk_sys);
	endtask
	initial begin
		repeat (4) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		i_rst = 1'b0;
		run(RCU_OP_RCL, RCU_CNT_ONE, 3'h0, 2'h0, 16'hA581, 8'h00, 1'b0);
		run(RCU_OP_RCL, RCU_CNT_ONE, 3'h7, 2'h1, 16'h4001, 8'h00, 1'b1);
		run(RCU_OP_RCR, RCU_CNT_ONE, 3'h0, 2'h0, 16'h0001, 8'h00, 1'b1);
		run(RCU_OP_RCR, RCU_CNT_ONE, 3'h6, 2'h2, 16'hC003, 8'h00, 1'b0);
		run(RCU_OP_RCL, RCU_CNT_REG, 3'h6, 2'h0, 16'h8421, 8'h09, 1'b0);
		run(RCU_OP_RCR, RCU_CNT_REG, 3'h3, 2'h1, 16'h0096, 8'h03, 1'b1);
		run(RCU_OP_ROTATE_RIGHT, RCU_CNT_IMM, 3'h2, 2'h1, 16'h0035, 8'h06, 1'b0);
		run(RCU_OP_ROTATE_RIGHT, RCU_CNT_IMM, 3'h4, 2'h0, 16'hB00D, 8'h11, 1'b0);
		run(RCU_OP_RCR, RCU_CNT_IMM, 3'h7, 2'h2, 16'h1234, 8'h00, 1'b1);
		run(RCU_OP_RCL, RCU_CNT_IMM, 3'h0, 2'h0, 16'h00FF, 8'hFF, 1'b0);
		test_done;
	end
endmodule
